// ---- rtl/sibt_device.sv ----
// SMBus indexed block target with output enable control
//
// Summary of operation
// - Answer only address 1101101, bit zero read/write.
// - Acknowledge the starting index after write address.
// - Acknowledge the count byte following the index.
// - Store data bytes at consecutive indices from N.
// - Acknowledge each written data byte separately.
// - Host ends block write with stop.
// - Read: index written, repeated start, read address acknowledged.
// - Send count byte before any register data.
// - Return consecutive registers, count from byte-count register.
// - Host acknowledges count and all but last.
// - Host ends read with not-acknowledge then stop.
// - Byte zero bit five enables output one.
// - Byte zero bit three enables output zero.
// - Cleared enable bit overrides output enable pin.
// - Written byte count sets read length.
`timescale 1ns/100ps
`default_nettype none
module sibt_device import sibt_pkg::*; (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // SMBus
   sibt_smb_if.dev   smb,
   // Output enable pins, active low
   input  wire logic diffOut0EnableN,
   input  wire logic diffOut1EnableN,
   // Gated run enables of the two differential outputs
   output var  logic diffOut0Run,
   output var  logic diffOut1Run
);

   function automatic logic [7:0] readReg(input logic [7:0] idx, input logic [7:0] oe,
                                          input logic [7:0] bc);
      case (idx)
         SIBT_IDX_OE: readReg = oe;
         SIBT_IDX_BC: readReg = bc;
         default:     readReg = SIBT_UNMAPPED;
      endcase
   endfunction : readReg

   logic [3:0]   pinMeta;
   logic [3:0]   pinSync;
   logic         sclPrev;
   logic         sdaPrev;
   logic         sclS;
   logic         sdaS;
   logic         oe0PinN;
   logic         oe1PinN;
   logic         sclRise;
   logic         sclFall;
   logic         startSeen;
   logic         stopSeen;

   sibt_dstate_t state;
   sibt_dstate_t next_state;
   sibt_phase_t  phase;
   sibt_phase_t  next_phase;
   logic [2:0]   bitCnt;
   logic [2:0]   next_bitCnt;
   logic [7:0]   shiftIn;
   logic [7:0]   next_shiftIn;
   logic [7:0]   txShift;
   logic [7:0]   next_txShift;
   logic [7:0]   ptr;
   logic [7:0]   next_ptr;
   logic [7:0]   remain;
   logic [7:0]   next_remain;
   logic         isRead;
   logic         next_isRead;
   logic         hostAck;
   logic         next_hostAck;
   logic         sdaOe;
   logic         next_sdaOe;
   logic [7:0]   oeCtrl;
   logic [7:0]   next_oeCtrl;
   logic [7:0]   byteCount;
   logic [7:0]   next_byteCount;
   logic         next_run0;
   logic         next_run1;
   logic [7:0]   rxb;

   // Pin synchronisers, then one more stage for edge detection
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pinMeta <= 4'hF;
         pinSync <= 4'hF;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         pinMeta <= {diffOut1EnableN, diffOut0EnableN, smb.sda, smb.scl};
         pinSync <= pinMeta;
         sclPrev <= pinSync[0];
         sdaPrev <= pinSync[1];
      end
   end

   assign sclS      = pinSync[0];
   assign sdaS      = pinSync[1];
   assign oe0PinN   = pinSync[2];
   assign oe1PinN   = pinSync[3];
   assign sclRise   = sclS && !sclPrev;
   assign sclFall   = !sclS && sclPrev;
   assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
   assign stopSeen  = sclS && sclPrev && !sdaPrev && sdaS;

   always_comb begin
      next_state     = state;
      next_phase     = phase;
      next_bitCnt    = bitCnt;
      next_shiftIn   = shiftIn;
      next_txShift   = txShift;
      next_ptr       = ptr;
      next_remain    = remain;
      next_isRead    = isRead;
      next_hostAck   = hostAck;
      next_oeCtrl    = oeCtrl;
      next_byteCount = byteCount;
      rxb            = {shiftIn[6:0], sdaS};
      if (startSeen) begin
         next_state  = D_RX;
         next_phase  = P_ADDR;
         next_bitCnt = 3'h0;
      end else if (stopSeen) begin
         next_state = D_IDLE;
      end else begin
         case (state)
            D_RX: begin
               if (sclRise) begin
                  next_shiftIn = rxb;
                  next_bitCnt  = bitCnt + 3'h1;
                  if (bitCnt == SIBT_LAST_BIT) begin
                     next_state = D_ACKPRE;
                     case (phase)
                        P_ADDR: begin
                           if (rxb[7:1] != SIBT_ADDR) begin
                              next_state = D_IDLE;
                           end else begin
                              next_isRead = rxb[0];
                              next_phase  = P_INDEX;
                           end
                        end
                        P_INDEX: begin
                           next_ptr   = rxb;
                           next_phase = P_COUNT;
                        end
                        P_COUNT: begin
                           next_remain = rxb;
                           next_phase  = P_DATA;
                        end
                        P_DATA: begin
                           // Bytes past the count are acknowledged and dropped
                           if (remain != 8'h00) begin
                              if (ptr == SIBT_IDX_OE) begin
                                 next_oeCtrl = (oeCtrl & ~SIBT_OE_WMASK)
                                             | (rxb & SIBT_OE_WMASK);
                              end
                              if (ptr == SIBT_IDX_BC) begin
                                 next_byteCount = rxb & SIBT_BC_WMASK;
                              end
                              next_ptr    = ptr + 8'h01;
                              next_remain = remain - 8'h01;
                           end
                        end
                        default: next_state = D_IDLE;
                     endcase
                  end
               end
            end
            D_ACKPRE: begin
               if (sclFall) begin
                  next_state = D_ACK;
               end
            end
            D_ACK: begin
               if (sclFall) begin
                  next_bitCnt = 3'h0;
                  if (isRead && phase == P_INDEX) begin
                     next_txShift = byteCount;
                     next_remain  = byteCount;
                     next_state   = D_TX;
                  end else begin
                     next_state = D_RX;
                  end
               end
            end
            D_TX: begin
               if (sclFall) begin
                  if (bitCnt == SIBT_LAST_BIT) begin
                     next_state = D_HACK;
                  end else begin
                     next_txShift = {txShift[6:0], 1'b1};
                     next_bitCnt  = bitCnt + 3'h1;
                  end
               end
            end
            D_HACK: begin
               if (sclRise) begin
                  next_hostAck = !sdaS;
               end
               if (sclFall) begin
                  if (hostAck && remain != 8'h00) begin
                     next_txShift = readReg(ptr, oeCtrl, byteCount);
                     next_ptr     = ptr + 8'h01;
                     next_remain  = remain - 8'h01;
                     next_bitCnt  = 3'h0;
                     next_state   = D_TX;
                  end else begin
                     next_state = D_IDLE;
                  end
               end
            end
            default: next_state = D_IDLE;
         endcase
      end
      case (next_state)
         D_ACK:   next_sdaOe = 1'b1;
         D_TX:    next_sdaOe = !next_txShift[7];
         default: next_sdaOe = 1'b0;
      endcase
      next_run0 = oeCtrl[SIBT_BIT_OE0] && !oe0PinN;
      next_run1 = oeCtrl[SIBT_BIT_OE1] && !oe1PinN;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state       <= D_IDLE;
         phase       <= P_ADDR;
         bitCnt      <= 3'h0;
         shiftIn     <= 8'h00;
         txShift     <= 8'hFF;
         ptr         <= 8'h00;
         remain      <= 8'h00;
         isRead      <= 1'b0;
         hostAck     <= 1'b0;
         sdaOe       <= 1'b0;
         oeCtrl      <= SIBT_OE_RESET;
         byteCount   <= SIBT_BC_RESET;
         diffOut0Run <= 1'b0;
         diffOut1Run <= 1'b0;
      end else begin
         state       <= next_state;
         phase       <= next_phase;
         bitCnt      <= next_bitCnt;
         shiftIn     <= next_shiftIn;
         txShift     <= next_txShift;
         ptr         <= next_ptr;
         remain      <= next_remain;
         isRead      <= next_isRead;
         hostAck     <= next_hostAck;
         sdaOe       <= next_sdaOe;
         oeCtrl      <= next_oeCtrl;
         byteCount   <= next_byteCount;
         diffOut0Run <= next_run0;
         diffOut1Run <= next_run1;
      end
   end

   // Open drain: only ever pulls low
   assign smb.devSdaOut = 1'b0;
   assign smb.devSdaOe  = sdaOe;

endmodule : sibt_device
`default_nettype wire

// ---- rtl/sibt_pkg.sv ----
// Shared constants and types for the SMBus indexed block target and its host
package sibt_pkg;
   // Target address, upper seven bits of the address byte
   localparam logic [6:0] SIBT_ADDR      = 7'h6D;
   localparam logic       SIBT_RD        = 1'h1;
   localparam logic       SIBT_WR        = 1'h0;
   // Register indices
   localparam logic [7:0] SIBT_IDX_OE    = 8'h00;
   localparam logic [7:0] SIBT_IDX_BC    = 8'h07;
   // Output enable control byte
   localparam logic [7:0] SIBT_OE_RESET  = 8'hFF;
   localparam logic [7:0] SIBT_OE_WMASK  = 8'h28;
   localparam int         SIBT_BIT_OE1   = 5;
   localparam int         SIBT_BIT_OE0   = 3;
   // Byte count register
   localparam logic [7:0] SIBT_BC_RESET  = 8'h08;
   localparam logic [7:0] SIBT_BC_WMASK  = 8'h1F;
   // Value returned for indices with no register
   localparam logic [7:0] SIBT_UNMAPPED  = 8'hFF;
   localparam logic [2:0] SIBT_LAST_BIT  = 3'h7;
   localparam logic [3:0] SIBT_ACK_SLOT  = 4'h8;
   // Bus timing: quarter of a 100 kHz bit period
   localparam int         SIBT_CLK_NS    = 50;
   localparam int         SIBT_QUARTER_NS = 2500;
   localparam int         SIBT_QUARTER_CYC = SIBT_QUARTER_NS / SIBT_CLK_NS;
   localparam logic [7:0] SIBT_Q_LAST    = 8'(SIBT_QUARTER_CYC - 1);

   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACKPRE, D_ACK, D_TX, D_HACK} sibt_dstate_t;
   typedef enum logic [1:0] {P_ADDR, P_INDEX, P_COUNT, P_DATA} sibt_phase_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_FRAME, H_STOP} sibt_hstate_t;
   typedef enum logic [2:0] {F_ADDRW, F_INDEX, F_COUNT, F_WDATA, F_ADDRR, F_RCOUNT,
                             F_RDATA} sibt_frame_t;
endpackage : sibt_pkg

// ---- rtl/sibt_smb_if.sv ----
// Open-drain SMBus wires between the host end and the target end
`timescale 1ns/100ps
`default_nettype none
interface sibt_smb_if;
   logic hostSclOut;
   logic hostSclOe;
   logic hostSdaOut;
   logic hostSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   logic scl;
   logic sda;

   // Pull-ups: a line is low while any party drives it
   assign scl = !(hostSclOe && !hostSclOut);
   assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

   modport dev  (input scl, input sda, output devSdaOut, output devSdaOe);
   modport host (input scl, input sda, output hostSclOut, output hostSclOe,
                 output hostSdaOut, output hostSdaOe);
endinterface : sibt_smb_if
`default_nettype wire

// ---- rtl/sibt_host.sv ----
// SMBus host end issuing indexed block writes and reads
`timescale 1ns/100ps
`default_nettype none
module sibt_host import sibt_pkg::*; (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // SMBus
   sibt_smb_if.host        smb,
   // Command
   input  wire logic       cmdStart,
   input  wire logic       cmdRead,
   input  wire logic [7:0] cmdIndex,
   input  wire logic [7:0] cmdCount,
   // Write data, consumed on wrTake
   input  wire logic [7:0] wrData,
   output var  logic       wrTake,
   // Read data and status
   output var  logic [7:0] rdData,
   output var  logic       rdValid,
   output var  logic       busy,
   output var  logic       done,
   output var  logic       nackErr
);

   logic [1:0]   meta;
   logic [1:0]   sync;
   sibt_hstate_t hs;
   sibt_hstate_t next_hs;
   sibt_frame_t  kind;
   sibt_frame_t  next_kind;
   logic [1:0]   q;
   logic [1:0]   next_q;
   logic [7:0]   tick;
   logic [7:0]   next_tick;
   logic [3:0]   bitIdx;
   logic [3:0]   next_bitIdx;
   logic [8:0]   shift;
   logic [8:0]   next_shift;
   logic [8:0]   cap;
   logic [8:0]   next_cap;
   logic [7:0]   left;
   logic [7:0]   next_left;
   logic         readMode;
   logic         next_readMode;
   logic         sclOe;
   logic         next_sclOe;
   logic         sdaOe;
   logic         next_sdaOe;
   logic         next_wrTake;
   logic [7:0]   next_rdData;
   logic         next_rdValid;
   logic         next_done;
   logic         next_nackErr;
   logic         qEnd;
   logic         sclLvl;
   logic         sdaLvl;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= 2'h3;
         sync <= 2'h3;
      end else begin
         meta <= {smb.sda, smb.scl};
         sync <= meta;
      end
   end

   // Quarter ends; a target holding the clock low stretches it
   assign qEnd = (tick == SIBT_Q_LAST) && !(!sclOe && !sync[0] && hs != H_IDLE);

   always_comb begin
      next_hs       = hs;
      next_kind     = kind;
      next_q        = q;
      next_tick     = tick;
      next_bitIdx   = bitIdx;
      next_shift    = shift;
      next_cap      = cap;
      next_left     = left;
      next_readMode = readMode;
      next_wrTake   = 1'b0;
      next_rdData   = rdData;
      next_rdValid  = 1'b0;
      next_done     = 1'b0;
      next_nackErr  = nackErr;
      if (hs == H_IDLE) begin
         next_tick = 8'h00;
         next_q    = 2'h0;
         if (cmdStart) begin
            next_hs       = H_START;
            next_kind     = F_ADDRW;
            next_shift    = {SIBT_ADDR, SIBT_WR, 1'b1};
            next_left     = cmdCount;
            next_readMode = cmdRead;
            next_nackErr  = 1'b0;
         end
      end else if (tick != SIBT_Q_LAST) begin
         next_tick = tick + 8'h01;
      end else if (qEnd) begin
         next_tick = 8'h00;
         next_q    = q + 2'h1;
         if (hs == H_FRAME && q == 2'h2) begin
            next_cap = {cap[7:0], sync[1]};
         end
         if (q == 2'h3) begin
            case (hs)
               H_START: begin
                  next_hs     = H_FRAME;
                  next_bitIdx = 4'h0;
               end
               H_STOP: begin
                  next_hs   = H_IDLE;
                  next_done = 1'b1;
               end
               H_FRAME: begin
                  if (bitIdx != SIBT_ACK_SLOT) begin
                     next_shift  = {shift[7:0], 1'b1};
                     next_bitIdx = bitIdx + 4'h1;
                  end else begin
                     next_bitIdx = 4'h0;
                     next_hs     = H_FRAME;
                     case (kind)
                        F_ADDRW, F_INDEX, F_COUNT, F_WDATA, F_ADDRR: begin
                           if (cap[0] && kind != F_COUNT) begin
                              next_hs      = H_STOP;
                              next_nackErr = 1'b1;
                           end else if (kind == F_ADDRW) begin
                              next_kind  = F_INDEX;
                              next_shift = {cmdIndex, 1'b1};
                           end else if (kind == F_INDEX && readMode) begin
                              next_hs    = H_START;
                              next_kind  = F_ADDRR;
                              next_shift = {SIBT_ADDR, SIBT_RD, 1'b1};
                           end else if (kind == F_INDEX) begin
                              next_kind  = F_COUNT;
                              next_shift = {left, 1'b1};
                           end else if (kind == F_ADDRR) begin
                              next_kind  = F_RCOUNT;
                              next_shift = {8'hFF, left == 8'h00};
                           end else if (left == 8'h00) begin
                              next_hs = H_STOP;
                           end else begin
                              next_kind   = F_WDATA;
                              next_shift  = {wrData, 1'b1};
                              next_wrTake = 1'b1;
                              next_left   = left - 8'h01;
                           end
                        end
                        default: begin
                           if (kind == F_RDATA) begin
                              next_rdData  = cap[8:1];
                              next_rdValid = 1'b1;
                           end
                           if (left == 8'h00) begin
                              next_hs = H_STOP;
                           end else begin
                              next_kind  = F_RDATA;
                              next_shift = {8'hFF, left == 8'h01};
                              next_left  = left - 8'h01;
                           end
                        end
                     endcase
                  end
               end
               default: next_hs = H_IDLE;
            endcase
         end
      end
      // Line levels for the coming quarter
      case (next_hs)
         H_START: begin
            sclLvl = next_q == 2'h1 || next_q == 2'h2;
            sdaLvl = next_q == 2'h0 || next_q == 2'h1;
         end
         H_FRAME: begin
            sclLvl = next_q == 2'h1 || next_q == 2'h2;
            sdaLvl = next_shift[8];
         end
         H_STOP: begin
            sclLvl = next_q != 2'h0;
            sdaLvl = next_q[1];
         end
         default: begin
            sclLvl = 1'b1;
            sdaLvl = 1'b1;
         end
      endcase
      next_sclOe = !sclLvl;
      next_sdaOe = !sdaLvl;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hs       <= H_IDLE;
         kind     <= F_ADDRW;
         q        <= 2'h0;
         tick     <= 8'h00;
         bitIdx   <= 4'h0;
         shift    <= 9'h1FF;
         cap      <= 9'h1FF;
         left     <= 8'h00;
         readMode <= 1'b0;
         sclOe    <= 1'b0;
         sdaOe    <= 1'b0;
         wrTake   <= 1'b0;
         rdData   <= 8'h00;
         rdValid  <= 1'b0;
         busy     <= 1'b0;
         done     <= 1'b0;
         nackErr  <= 1'b0;
      end else begin
         hs       <= next_hs;
         kind     <= next_kind;
         q        <= next_q;
         tick     <= next_tick;
         bitIdx   <= next_bitIdx;
         shift    <= next_shift;
         cap      <= next_cap;
         left     <= next_left;
         readMode <= next_readMode;
         sclOe    <= next_sclOe;
         sdaOe    <= next_sdaOe;
         wrTake   <= next_wrTake;
         rdData   <= next_rdData;
         rdValid  <= next_rdValid;
         busy     <= next_hs != H_IDLE;
         done     <= next_done;
         nackErr  <= next_nackErr;
      end
   end

   assign smb.hostSclOut = 1'b0;
   assign smb.hostSclOe  = sclOe;
   assign smb.hostSdaOut = 1'b0;
   assign smb.hostSdaOe  = sdaOe;

endmodule : sibt_host
`default_nettype wire

// ---- verification/sibt_checker.sv ----
// Protocol checks on the SMBus wires between the host end and the target end
`timescale 1ns/100ps
`default_nettype none
module sibt_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   input wire logic hostSdaOe,
   input wire logic devSdaOe
);
   logic       prevScl;
   logic       prevSda;
   logic [7:0] riseCnt;
   logic       next_prevScl;
   logic       next_prevSda;
   logic [7:0] next_riseCnt;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // SCL rises since the last start, saturating
   always_comb begin
      next_prevScl = scl;
      next_prevSda = sda;
      next_riseCnt = riseCnt;
      if (scl && prevScl && prevSda && !sda) begin
         next_riseCnt = 8'h00;
      end else if (scl && !prevScl && riseCnt != 8'hFF) begin
         next_riseCnt = riseCnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prevScl <= 1'b1;
         prevSda <= 1'b1;
         riseCnt <= 8'h00;
      end else begin
         prevScl <= next_prevScl;
         prevSda <= next_prevSda;
         riseCnt <= next_riseCnt;
      end
   end

   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_slot(logic [7:0] n);
      $rose(scl) && riseCnt == n;
   endsequence

   a_dev_change_low: assert property ($changed(devSdaOe) |-> !scl)
      else $error("target SDA enable changed while SCL high");
   a_no_contention: assert property (scl |-> !(devSdaOe && hostSdaOe))
      else $error("host and target drive SDA together");
   a_sda_high_stable: assert property (scl && $past(scl) && $changed(sda) |->
      $changed(hostSdaOe) && !devSdaOe)
      else $error("SDA moved under high SCL not by host");
   a_stop_released: assert property (scl && $rose(sda) |-> !devSdaOe)
      else $error("target holds SDA at stop");
   a_addr_ack: assert property (s_slot(8'h08) |-> devSdaOe && !sda)
      else $error("address not acknowledged by target");
   a_second_ack: assert property (s_slot(8'h11) |-> !sda)
      else $error("second frame not acknowledged");
   a_scl_low_bound: assert property ($fell(scl) |-> ##[1:400] $rose(scl))
      else $error("SCL held low too long");
   a_start_then_fall: assert property (s_start |-> ##[1:200] $fell(scl))
      else $error("no clock after start");
endmodule : sibt_checker
`default_nettype wire

// ---- verification/tb_smbus_index_block_target.sv ----
// Block write and block read tests across the host and target ends
`timescale 1ns/100ps
`default_nettype none
module tb_smbus_index_block_target import sibt_pkg::*; ();
   logic       core_clk = 1'b0;
   logic       rst      = 1'b1;
   logic       cmdStart = 1'b0;
   logic       cmdRead  = 1'b0;
   logic [7:0] cmdIndex = 8'h00;
   logic [7:0] cmdCount = 8'h00;
   logic       pin0N    = 1'b0;
   logic       pin1N    = 1'b0;
   logic [7:0] wBuf [2] = '{8'h00, 8'h00};
   logic [7:0] rBuf [2];
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic       wrTake, rdValid, busy, done, nackErr, run0, run1;
   int         wPtr = 0;
   int         rPtr = 0;
   int         n_fail = 0;
   int         cmp_count = 0;

   always #25 core_clk = ~core_clk;
   assign wrData = wBuf[wPtr[0]];

   sibt_smb_if smb ();
   sibt_device sibt_device_inst (.core_clk(core_clk), .rst(rst), .smb(smb),
      .diffOut0EnableN(pin0N), .diffOut1EnableN(pin1N), .diffOut0Run(run0), .diffOut1Run(run1));
   sibt_host sibt_host_inst (.core_clk(core_clk), .rst(rst), .smb(smb), .cmdStart(cmdStart),
      .cmdRead(cmdRead), .cmdIndex(cmdIndex), .cmdCount(cmdCount), .wrData(wrData),
      .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .busy(busy), .done(done),
      .nackErr(nackErr));
   sibt_checker sibt_checker_inst (.core_clk(core_clk), .rst(rst), .scl(smb.scl),
      .sda(smb.sda), .hostSdaOe(smb.hostSdaOe), .devSdaOe(smb.devSdaOe));

   // Pointers restart per command; next write byte after each take, reads in order
   always @(posedge core_clk) begin
      if (cmdStart) begin
         wPtr <= 0;
         rPtr <= 0;
      end
      if (wrTake) wPtr <= wPtr + 1;
      if (rdValid) begin
         rBuf[rPtr[0]] <= rdData;
         rPtr <= rPtr + 1;
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] cnt,
                       input logic [7:0] d0, input logic [7:0] d1);
      int i;
      @(posedge core_clk);
      wBuf[0] <= d0;
      wBuf[1] <= d1;
      cmdStart <= 1'b1;
      cmdRead <= rd;
      cmdIndex <= idx;
      cmdCount <= cnt;
      @(posedge core_clk);
      cmdStart <= 1'b0;
      @(posedge core_clk);
      chk("busy", 8'h01, {7'h00, busy});
      i = 0;
      while (done !== 1'b1 && i < 40000) begin
         @(posedge core_clk);
         i++;
      end
      chk("done", 8'h01, {7'h00, done});
      chk("busy", 8'h00, {7'h00, busy});
      chk("nackErr", 8'h00, {7'h00, nackErr});
   endtask : xfer

   // Run outputs settle three edges after any change
   task automatic ck_run(input logic e0, input logic e1);
      repeat (4) @(posedge core_clk);
      chk("diffOut0Run", {7'h00, e0}, {7'h00, run0});
      chk("diffOut1Run", {7'h00, e1}, {7'h00, run1});
   endtask : ck_run

   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      ck_run(1'b1, 1'b1);
      pin0N <= 1'b1;
      ck_run(1'b0, 1'b1);
      pin0N <= 1'b0;
      xfer(1'b0, SIBT_IDX_OE, 8'h01, 8'h00, 8'h00);
      ck_run(1'b0, 1'b0);
      xfer(1'b1, SIBT_IDX_OE, 8'h01, 8'h00, 8'h00);
      chk("byte0", SIBT_OE_RESET & ~SIBT_OE_WMASK, rBuf[0]);
      xfer(1'b0, SIBT_IDX_OE, 8'h01, 8'h20, 8'h00);
      ck_run(1'b0, 1'b1);
      pin1N <= 1'b1;
      ck_run(1'b0, 1'b0);
      xfer(1'b1, 8'h06, 8'h02, 8'h00, 8'h00);
      chk("byte6", SIBT_UNMAPPED, rBuf[0]);
      chk("byte7", SIBT_BC_RESET, rBuf[1]);
      xfer(1'b0, 8'h06, 8'h02, 8'h55, 8'h01);
      xfer(1'b1, 8'h06, 8'h02, 8'h00, 8'h00);
      chk("byte6", SIBT_UNMAPPED, rBuf[0]);
      chk("pastCount", 8'hFF, rBuf[1]);
      test_done();
   end

   initial begin
      repeat (95000) @(posedge core_clk);
      n_fail++;
      $display("Error watchdog expected finish seen timeout");
      test_done();
   end
endmodule : tb_smbus_index_block_target
`default_nettype wire
